// ==== src/motor_drive_pkg.sv ====
package motor_drive_pkg;

	// Core clock and the one millisecond time base derived from it.
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned TICK_MS        = 1;
	localparam int unsigned MS_TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned TICK_W         = 15;
	localparam int unsigned MS_W           = 13;

	// Register offsets on the configuration port.
	localparam logic [5:0] OFF_STATUS    = 6'h01;
	localparam logic [5:0] OFF_FAULT_CLR = 6'h04;
	localparam logic [5:0] OFF_RECT      = 6'h07;
	localparam logic [5:0] OFF_REGULATOR = 6'h08;
	localparam logic [5:0] OFF_MOTION    = 6'h09;
	localparam logic [5:0] OFF_LOCK      = 6'h0a;
	localparam logic [5:0] OFF_ADVANCE   = 6'h0b;

	// Values after reset.
	localparam logic [7:0] RECT_RST      = 8'h00;
	localparam logic [7:0] REGULATOR_RST = 8'h00;
	localparam logic [7:0] MOTION_RST    = 8'h00;
	localparam logic [7:0] LOCK_RST      = 8'h00;
	localparam logic [7:0] ADVANCE_RST   = 8'h00;

	// Writable bits; the others read as zero.
	localparam logic [7:0] RECT_WMASK      = 8'hff;
	localparam logic [7:0] REGULATOR_WMASK = 8'h3f;
	localparam logic [7:0] MOTION_WMASK    = 8'h1f;
	localparam logic [7:0] LOCK_WMASK      = 8'hdf;
	localparam logic [7:0] ADVANCE_WMASK   = 8'h07;

	// Field positions.
	localparam int unsigned RECIRC_BIT   = 6;
	localparam int unsigned AAR_BIT      = 3;
	localparam int unsigned ASR_BIT      = 2;
	localparam int unsigned GAIN_LSB     = 0;
	localparam int unsigned SEQ_OFF_BIT  = 4;
	localparam int unsigned ILIMIT_BIT   = 3;
	localparam int unsigned VSEL_LSB     = 1;
	localparam int unsigned REG_OFF_BIT  = 0;
	localparam int unsigned HYST_BIT     = 4;
	localparam int unsigned BRK_MODE_BIT = 3;
	localparam int unsigned COAST_BIT    = 2;
	localparam int unsigned BRAKE_BIT    = 1;
	localparam int unsigned DIR_BIT      = 0;
	localparam int unsigned FB_SEL_LSB   = 6;
	localparam int unsigned RETRY_BIT    = 4;
	localparam int unsigned DET_LSB      = 2;
	localparam int unsigned RESP_LSB     = 0;
	localparam int unsigned CLR_BIT      = 0;

	// Stall timing in milliseconds.
	localparam logic [MS_W-1:0] RETRY_SHORT_MS = 13'd500;
	localparam logic [MS_W-1:0] RETRY_LONG_MS  = 13'd5000;
	localparam logic [MS_W-1:0] DET0_MS        = 13'd300;
	localparam logic [MS_W-1:0] DET1_MS        = 13'd500;
	localparam logic [MS_W-1:0] DET2_MS        = 13'd1000;
	localparam logic [MS_W-1:0] DET3_MS        = 13'd5000;

	// Commutation steps per speed feedback half period.
	localparam logic [3:0] FB_DIV0 = 4'h1;
	localparam logic [3:0] FB_DIV1 = 4'h3;
	localparam logic [3:0] FB_DIV2 = 4'h6;
	localparam logic [3:0] FB_DIV3 = 4'hc;

	// Stall response codes.
	localparam logic [1:0] RESP_LATCH  = 2'h0;
	localparam logic [1:0] RESP_RETRY  = 2'h1;
	localparam logic [1:0] RESP_REPORT = 2'h2;
	localparam logic [1:0] RESP_IGNORE = 2'h3;

	typedef enum logic [2:0] {
		ST_RUN     = 3'b001,
		ST_LATCHED = 3'b010,
		ST_RETRY   = 3'b100
	} stall_state_t;

	typedef enum logic [1:0] {
		BR_DRIVE = 2'h0,
		BR_BRAKE = 2'h1,
		BR_COAST = 2'h2
	} bridge_mode_t;

	typedef struct packed {
		logic       wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic       limit_recirc_sel;
		logic       async_active_rect_en;
		logic       sync_active_rect_en;
		logic [1:0] sense_gain_sel;
		logic       regulator_seq_off;
		logic       regulator_ilimit_sel;
		logic [1:0] regulator_vsel;
		logic       regulator_off;
		logic       position_cmp_hyst;
		logic       direction;
	} drive_cfg_t;

endpackage : motor_drive_pkg

// ==== src/speed_fb_div.sv ====
module speed_fb_div (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       step,
	input  wire logic [1:0] sel,
	output logic            speed_fb_out
);
	import motor_drive_pkg::*;

	logic [3:0] cnt_q;
	logic [3:0] div;

	// Toggling every N steps halves the rate again, so six steps make one electrical cycle.
	always_comb begin
		case (sel)
			2'h0:    div = FB_DIV0;
			2'h1:    div = FB_DIV1;
			2'h2:    div = FB_DIV2;
			default: div = FB_DIV3;
		endcase
	end

	// Steps are counted; the output toggles at the end of each group.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q        <= 4'h0;
			speed_fb_out <= 1'b0;
		end else if (step) begin
			if (cnt_q >= div - 4'h1) begin
				cnt_q        <= 4'h0;
				speed_fb_out <= ~speed_fb_out;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	AST_FB_STILL: assert property (@(posedge clk) disable iff (!resetn)
		!step |=> $stable(speed_fb_out)) else $error("Speed output moved without a step.");

endmodule : speed_fb_div

// ==== src/motor_drive_control_regs.sv ====
// Functional notes
// - Recirculation bit 6: zero recirculates through transistors, one through diodes.
// - Rectification bit 3 enables active asynchronous rectification.
// - Rectification bit 2 enables active synchronous rectification.
// - Gain bits 1-0 pick 0.15, 0.3, 0.6 or 1.2 volts per ampere.
// - Regulator bit 4 set turns buck power sequencing off.
// - Regulator bit 3 picks 600 mA when clear, 150 mA when set.
// - Regulator bits 2-1 pick 3.3, 5.0, 4.0 or 5.7 volts.
// - Regulator bit 0 set disables the buck regulator.
// - Motion bit 4 picks 5 mV or 50 mV Hall hysteresis.
// - A requested brake really brakes when motion bit 3 is zero, else coasts.
// - Motion bit 2 set puts the drive into coast.
// - Motion bit 1 set puts the drive into brake.
// - Motion bit 0 picks clockwise when zero, anti-clockwise when one.
// - Lock bits 7-6 set speed output at 3x, 1x, 0.5x or 0.25x.
// - Lock bit 4 picks 500 ms or 5000 ms retry wait.
// - Lock bits 3-2 pick 300, 500, 1000 or 5000 ms detection time.
// - Response code 0 latches the stall fault until software clears it.
// - Response code 1 faults, waits the retry time, then resumes by itself.
// - Response code 2 only reports the stall; driving carries on.
// - Response code 3 neither reports nor acts on a stall.
// - Regulator, motion and lock registers reset to zero.
// - Writing one to the clear bit clears a latched or report-only fault, not a retry wait; the bit clears itself.
module motor_drive_control_regs #(
	parameter int unsigned TICK_CYCLES = motor_drive_pkg::MS_TICK_CYCLES
) (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire motor_drive_pkg::reg_req_t     req,
	output logic [7:0]                         rdata,
	input  wire logic [2:0]                    hall,
	input  wire logic                          drive_req,
	input  wire logic                          brake_in,
	output motor_drive_pkg::drive_cfg_t        cfg,
	output motor_drive_pkg::bridge_mode_t      bridge_mode,
	output logic                               stall_fault,
	output logic                               speed_fb_out
);
	import motor_drive_pkg::*;

	logic [7:0]          rect_q;
	logic [7:0]          regulator_q;
	logic [7:0]          motion_q;
	logic [7:0]          lock_q;
	logic [7:0]          advance_q;
	logic                clr_q;
	logic [7:0]          rdata_d;
	logic [2:0]          hall_q;
	logic                valid_step;
	logic [TICK_W-1:0]   tick_cnt_q;
	logic                tick;
	logic [MS_W-1:0]     det_cnt_q;
	logic [MS_W-1:0]     retry_cnt_q;
	logic [MS_W-1:0]     det_limit;
	logic [MS_W-1:0]     retry_limit;
	logic [1:0]          resp;
	logic                driving;
	logic                stall_hit;
	logic                report_q;
	stall_state_t        state_q;
	stall_state_t        state_d;
	bridge_mode_t        bridge_d;

	// A write is accepted only when it hits the given offset.
	function automatic logic hit(input reg_req_t r, input logic [5:0] off);
		return r.wr && (r.addr == off);
	endfunction : hit

	// Detection time in milliseconds for a field code.
	function automatic logic [MS_W-1:0] det_ms(input logic [1:0] code);
		case (code)
			2'h0:    return DET0_MS;
			2'h1:    return DET1_MS;
			2'h2:    return DET2_MS;
			default: return DET3_MS;
		endcase
	endfunction : det_ms

	// Configuration registers; reserved read-only bits are masked off on write.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rect_q      <= RECT_RST;
			regulator_q <= REGULATOR_RST;
			motion_q    <= MOTION_RST;
			lock_q      <= LOCK_RST;
			advance_q   <= ADVANCE_RST;
		end else begin
			if (hit(req, OFF_RECT)) begin
				rect_q <= req.wdata & RECT_WMASK;
			end
			if (hit(req, OFF_REGULATOR)) begin
				regulator_q <= req.wdata & REGULATOR_WMASK;
			end
			if (hit(req, OFF_MOTION)) begin
				motion_q <= req.wdata & MOTION_WMASK;
			end
			if (hit(req, OFF_LOCK)) begin
				lock_q <= req.wdata & LOCK_WMASK;
			end
			if (hit(req, OFF_ADVANCE)) begin
				advance_q <= req.wdata & ADVANCE_WMASK;
			end
		end
	end

	// The clear command lives for exactly one cycle after the write that sets it.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clr_q <= 1'b0;
		end else begin
			clr_q <= hit(req, OFF_FAULT_CLR) && req.wdata[CLR_BIT];
		end
	end

	// Field outputs come straight from the register flops.
	assign cfg.limit_recirc_sel     = rect_q[RECIRC_BIT];
	assign cfg.async_active_rect_en = rect_q[AAR_BIT];
	assign cfg.sync_active_rect_en  = rect_q[ASR_BIT];
	assign cfg.sense_gain_sel       = rect_q[GAIN_LSB+:2];
	assign cfg.regulator_seq_off    = regulator_q[SEQ_OFF_BIT];
	assign cfg.regulator_ilimit_sel = regulator_q[ILIMIT_BIT];
	assign cfg.regulator_vsel       = regulator_q[VSEL_LSB+:2];
	assign cfg.regulator_off        = regulator_q[REG_OFF_BIT];
	assign cfg.position_cmp_hyst    = motion_q[HYST_BIT];
	assign cfg.direction            = motion_q[DIR_BIT];

	// Read data; the clear offset is not decoded here, so it always reads zero.
	always_comb begin
		case (req.addr)
			OFF_STATUS:    rdata_d = {5'h00, state_q == ST_RETRY, state_q == ST_LATCHED, stall_fault};
			OFF_RECT:      rdata_d = rect_q;
			OFF_REGULATOR: rdata_d = regulator_q;
			OFF_MOTION:    rdata_d = motion_q;
			OFF_LOCK:      rdata_d = lock_q;
			OFF_ADVANCE:   rdata_d = advance_q;
			default:       rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rdata_d;
		end
	end

	// The all-low and all-high codes are not positions, so moving into them is no step.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hall_q <= 3'h0;
		end else begin
			hall_q <= hall;
		end
	end

	assign valid_step = (hall != hall_q) && (hall != 3'h0) && (hall != 3'h7);

	// Millisecond time base for both stall timers.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_q <= '0;
		end else if (tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	assign tick        = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));
	assign resp        = lock_q[RESP_LSB+:2];
	assign det_limit   = det_ms(lock_q[DET_LSB+:2]);
	assign retry_limit = lock_q[RETRY_BIT] ? RETRY_LONG_MS : RETRY_SHORT_MS;
	assign driving     = drive_req && (state_q == ST_RUN) && (bridge_mode == BR_DRIVE);

	// Detection timer restarts on every valid step and whenever the bridge is not driving.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			det_cnt_q <= '0;
		end else if (!driving || valid_step) begin
			det_cnt_q <= '0;
		end else if (tick && det_cnt_q < det_limit) begin
			det_cnt_q <= det_cnt_q + 1'b1;
		end
	end

	// Compared with >= so a shorter time written mid-count still fires.
	assign stall_hit = driving && (det_cnt_q >= det_limit) && (resp != RESP_IGNORE);

	// Retry wait timer runs only while waiting to retry.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			retry_cnt_q <= '0;
		end else if (state_q != ST_RETRY) begin
			retry_cnt_q <= '0;
		end else if (tick && retry_cnt_q < retry_limit) begin
			retry_cnt_q <= retry_cnt_q + 1'b1;
		end
	end

	// Stall response sequencing.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (stall_hit && resp == RESP_LATCH) begin
					state_d = ST_LATCHED;
				end else if (stall_hit && resp == RESP_RETRY) begin
					state_d = ST_RETRY;
				end
			end
			ST_LATCHED: begin
				if (clr_q) begin
					state_d = ST_RUN;
				end
			end
			ST_RETRY: begin
				if (retry_cnt_q >= retry_limit) begin
					state_d = ST_RUN;
				end
			end
			default: state_d = ST_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Report-only flag; a new stall in the clearing cycle keeps it set.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			report_q <= 1'b0;
		end else if (stall_hit && resp == RESP_REPORT) begin
			report_q <= 1'b1;
		end else if (clr_q) begin
			report_q <= 1'b0;
		end
	end

	assign stall_fault = (state_q != ST_RUN) || report_q;

	// Coast outranks brake, and a latched or retrying stall (not a report-only one) forces coast so the stuck rotor is not heated.
	always_comb begin
		if (motion_q[COAST_BIT] || state_q != ST_RUN) begin
			bridge_d = BR_COAST;
		end else if (motion_q[BRAKE_BIT] || brake_in) begin
			bridge_d = motion_q[BRK_MODE_BIT] ? BR_COAST : BR_BRAKE;
		end else begin
			bridge_d = BR_DRIVE;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bridge_mode <= BR_DRIVE;
		end else begin
			bridge_mode <= bridge_d;
		end
	end

	// Speed feedback counts the same valid steps that feed stall detection.
	speed_fb_div i_speed_fb_div (
		.clk          (clk),
		.resetn       (resetn),
		.step         (valid_step),
		.sel          (lock_q[FB_SEL_LSB+:2]),
		.speed_fb_out (speed_fb_out)
	);

	// Split in two so that back-to-back clear writes, which the port allows, stay legal.
	AST_CLR_PULSE: assert property (@(posedge clk) disable iff (!resetn)
		hit(req, OFF_FAULT_CLR) && req.wdata[CLR_BIT] |=> clr_q)
		else $error("Clear command did not follow its write.");

	AST_CLR_SELF: assert property (@(posedge clk) disable iff (!resetn)
		clr_q |-> $past(hit(req, OFF_FAULT_CLR) && req.wdata[CLR_BIT]))
		else $error("Clear command stayed set without a new write.");

	AST_COAST: assert property (@(posedge clk) disable iff (!resetn)
		motion_q[COAST_BIT] |=> bridge_mode == BR_COAST) else $error("Coast bit not obeyed.");

	AST_BRAKE: assert property (@(posedge clk) disable iff (!resetn)
		motion_q[BRAKE_BIT] && !motion_q[COAST_BIT] && !motion_q[BRK_MODE_BIT] && state_q == ST_RUN
		|=> bridge_mode == BR_BRAKE) else $error("Brake bit not obeyed.");

	AST_BRAKE_AS_COAST: assert property (@(posedge clk) disable iff (!resetn)
		(motion_q[BRAKE_BIT] || brake_in) && motion_q[BRK_MODE_BIT] |=> bridge_mode == BR_COAST)
		else $error("Brake did not coast with brake mode set.");

	AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_LATCHED && !clr_q |=> state_q == ST_LATCHED && stall_fault)
		else $error("Latched fault left without a clear.");

	AST_RETRY_END: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_RETRY && retry_cnt_q >= retry_limit |=> state_q == ST_RUN)
		else $error("Retry did not resume the drive.");

	AST_REPORT_ONLY: assert property (@(posedge clk) disable iff (!resetn)
		stall_hit && resp == RESP_REPORT |=> state_q == ST_RUN && report_q)
		else $error("Report-only stall changed the drive.");

	AST_IGNORE: assert property (@(posedge clk) disable iff (!resetn)
		$rose(stall_fault) |-> $past(resp) != RESP_IGNORE) else $error("Ignored stall was reported.");

	AST_RESET_ZERO: assert property (@(posedge clk) disable iff (!resetn)
		!$past(resetn) |-> regulator_q == 8'h00 && motion_q == 8'h00 && lock_q == 8'h00)
		else $error("Control registers not zero after reset.");

	AST_STALL_TIME: assert property (@(posedge clk) disable iff (!resetn)
		$rose(stall_hit) |-> det_cnt_q >= det_limit && !$past(valid_step)) else $error("Early stall.");

	COV_LATCH: cover property (@(posedge clk) disable iff (!resetn) state_q == ST_LATCHED ##1 clr_q);
	COV_RETRY: cover property (@(posedge clk) disable iff (!resetn) state_q == ST_RETRY ##1 state_q == ST_RUN);
	COV_BRAKE: cover property (@(posedge clk) disable iff (!resetn) bridge_mode == BR_BRAKE);

endmodule : motor_drive_control_regs

// ==== tb/hall_motor_model.sv ====
module hall_motor_model #(
	parameter int unsigned STEP_CYCLES = 20
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       spin,
	input  wire logic       dir,
	output logic [2:0]      hall
);
	timeunit 1ns;
	timeprecision 1ps;

	// Healthy sensors only ever show these six codes, never 000 or 111.
	localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};

	logic [2:0]  pos_q;
	int unsigned cnt_q;

	// A stalled rotor holds its sensor levels, so the code only moves while spinning.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 0;
			pos_q <= 3'h0;
		end else if (spin) begin
			if (cnt_q == STEP_CYCLES - 1) begin
				cnt_q <= 0;
				if (dir)
					pos_q <= (pos_q == 3'h0) ? 3'h5 : pos_q - 3'h1;
				else
					pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
			end else begin
				cnt_q <= cnt_q + 1;
			end
		end
	end

	assign hall = SEQ[pos_q];
endmodule : hall_motor_model

// ==== tb/tb_motor_drive_control_regs.sv ====
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_motor_drive_control_regs;
	import motor_drive_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// Short millisecond tick keeps the multi-second stall timers affordable.
	localparam int unsigned TK = 4;
	localparam int unsigned M  = 40;

	logic         clk;
	logic         resetn;
	reg_req_t     req;
	logic [7:0]   rdata;
	logic [2:0]   hall;
	logic         drive_req;
	logic         brake_in;
	logic         spin;
	drive_cfg_t   cfg;
	bridge_mode_t bridge_mode;
	logic         stall_fault;
	logic         speed_fb_out;
	int           err_count;
	int           samples_checked;
	int           cycles;

	motor_drive_control_regs #(.TICK_CYCLES(TK)) i_motor_drive_control_regs (
		.clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .hall(hall), .drive_req(drive_req),
		.brake_in(brake_in), .cfg(cfg), .bridge_mode(bridge_mode), .stall_fault(stall_fault),
		.speed_fb_out(speed_fb_out));

	hall_motor_model #(.STEP_CYCLES(20)) i_hall_motor_model (
		.clk(clk), .resetn(resetn), .spin(spin), .dir(1'b0), .hall(hall));

	// Free-running core clock at 25 MHz.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Cuts a hang short; the tests need roughly sixty thousand cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("err_count=%0d samples_checked=%0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic cyc(input int unsigned n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// One-cycle write strobe, then time for the fields and bridge mode to follow.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, addr: a, wdata: d};
		@(negedge clk);
		req.wr = 1'b0;
		cyc(2);
	endtask : wr

	// Read data is registered, so it is taken one edge after the offset is set.
	task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
		@(negedge clk);
		req.addr = a;
		@(negedge clk);
		`CHK(rdata, exp)
	endtask : rchk

	// Restart stall timing from scratch with a fresh lock setting.
	task automatic arm(input logic [7:0] lock);
		drive_req = 1'b0;
		wr(OFF_FAULT_CLR, 8'h01);
		wr(OFF_LOCK, lock);
		drive_req = 1'b1;
	endtask : arm

	// Counts Hall steps between two consecutive speed output toggles.
	task automatic fb_steps(output int n);
		logic       s;
		logic [2:0] h;
		int         k;
		s = speed_fb_out;
		k = 0;
		while (speed_fb_out === s && k < 2000) begin
			@(negedge clk);
			k++;
		end
		s = speed_fb_out;
		h = hall;
		n = 0;
		k = 0;
		while (speed_fb_out === s && k < 2000) begin
			@(negedge clk);
			k++;
			if (hall !== h) begin
				n++;
				h = hall;
			end
		end
	endtask : fb_steps

	localparam logic [5:0]   OFFS [5] = '{OFF_RECT, OFF_REGULATOR, OFF_MOTION, OFF_LOCK, OFF_ADVANCE};
	localparam logic [7:0]   MSKS [5] = '{8'hff, 8'h3f, 8'h1f, 8'hdf, 8'h07};
	localparam logic [7:0]   MV [7]   = '{8'h02, 8'h0a, 8'h04, 8'h06, 8'h00, 8'h08, 8'h00};
	localparam logic         BI [7]   = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	localparam bridge_mode_t BM [7]   = '{BR_BRAKE, BR_COAST, BR_COAST, BR_COAST, BR_BRAKE, BR_COAST, BR_DRIVE};
	localparam int unsigned  DET [4]  = '{300, 500, 1000, 5000};
	localparam int unsigned  DIV [4]  = '{1, 3, 6, 12};

	// Main sequence: register map, field outputs, bridge modes, stall handling, speed output.
	initial begin
		logic [1:0]  g;
		int unsigned rt;
		int          n;
		resetn = 1'b0;
		req = '0;
		drive_req = 1'b0;
		brake_in = 1'b0;
		spin = 1'b0;
		err_count = 0;
		samples_checked = 0;
		cycles = 0;
		cyc(8);
		resetn = 1'b1;
		for (int i = 1; i < 4; i++) rchk(OFFS[i], 8'h00);
		`CHK(bridge_mode, BR_DRIVE)
		for (int i = 0; i < 5; i++) begin
			wr(OFFS[i], 8'hff);
			rchk(OFFS[i], MSKS[i]);
		end
		wr(6'h3f, 8'hff);
		rchk(6'h3f, 8'h00);
		for (int i = 0; i < 4; i++) begin
			g = i[1:0];
			wr(OFF_RECT, {1'b0, g[0], 2'b00, g[1], ~g[0], g});
			wr(OFF_REGULATOR, {3'b000, g[0], g[1], g, ~g[1]});
			wr(OFF_MOTION, {3'b000, g[1], 3'b000, g[0]});
			`CHK(cfg.limit_recirc_sel, g[0])
			`CHK(cfg.async_active_rect_en, g[1])
			`CHK(cfg.sync_active_rect_en, ~g[0])
			`CHK(cfg.sense_gain_sel, g)
			`CHK(cfg.regulator_seq_off, g[0])
			`CHK(cfg.regulator_ilimit_sel, g[1])
			`CHK(cfg.regulator_vsel, g)
			`CHK(cfg.regulator_off, ~g[1])
			`CHK(cfg.position_cmp_hyst, g[1])
			`CHK(cfg.direction, g[0])
		end
		for (int i = 0; i < 7; i++) begin
			brake_in = BI[i];
			wr(OFF_MOTION, MV[i]);
			`CHK(bridge_mode, BM[i])
		end
		// Latched response across all four detection times; stalled rotor throughout.
		for (int c = 0; c < 4; c++) begin
			arm({4'h0, c[1:0], RESP_LATCH});
			cyc(DET[c] * TK - M);
			`CHK(stall_fault, 1'b0)
			cyc(2 * M);
			`CHK(stall_fault, 1'b1)
			`CHK(bridge_mode, BR_COAST)
		end
		cyc(3000);
		`CHK(stall_fault, 1'b1)
		rchk(OFF_STATUS, 8'h03);
		wr(OFF_FAULT_CLR, 8'h01);
		`CHK(stall_fault, 1'b0)
		rchk(OFF_FAULT_CLR, 8'h00);
		// Retrying response with both retry waits.
		for (int r = 0; r < 2; r++) begin
			rt = (r == 0) ? 500 : 5000;
			arm({3'h0, r[0], 2'h0, RESP_RETRY});
			cyc(300 * TK + M);
			`CHK(stall_fault, 1'b1)
			cyc(rt * TK - 2 * M);
			`CHK(stall_fault, 1'b1)
			rchk(OFF_STATUS, 8'h05);
			cyc(2 * M);
			`CHK(stall_fault, 1'b0)
			`CHK(bridge_mode, BR_DRIVE)
		end
		arm({6'h00, RESP_REPORT});
		cyc(300 * TK + M);
		`CHK(stall_fault, 1'b1)
		`CHK(bridge_mode, BR_DRIVE)
		rchk(OFF_STATUS, 8'h01);
		arm({6'h00, RESP_IGNORE});
		cyc(300 * TK + M);
		`CHK(stall_fault, 1'b0)
		`CHK(bridge_mode, BR_DRIVE)
		// A turning rotor keeps resetting the stall timer.
		spin = 1'b1;
		arm({6'h00, RESP_LATCH});
		cyc(300 * TK * 2);
		`CHK(stall_fault, 1'b0)
		for (int c = 0; c < 4; c++) begin
			wr(OFF_LOCK, {c[1:0], 6'h00});
			fb_steps(n);
			fb_steps(n);
			`CHK(n, DIV[c])
		end
		// A reset in mid-run must bring registers that hold live values back to zero.
		wr(OFF_MOTION, 8'h11);
		rchk(OFF_MOTION, 8'h11);
		@(negedge clk);
		resetn = 1'b0;
		cyc(2);
		resetn = 1'b1;
		for (int i = 1; i < 4; i++) rchk(OFFS[i], 8'h00);
		give_verdict();
	end
endmodule : tb_motor_drive_control_regs
